// ==== hdl/uartps_core.sv ====
// serial interface: parity, status flags, interrupt, sync clock, bus slave
`default_nettype none

module uartps_core
  import uartps_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // processor state
  input  wire logic        cpu_int_mask,
  input  wire logic        wait_mode,
  input  wire logic        halt_mode,
  output logic             irq,
  output logic             wake_req,
  // serial pins
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             tx_oe,
  output logic             sclk_out,
  output logic             sclk_oe
);

  uartps_state_t st;
  uartps_state_t nx;
  logic          load_data;
  logic          rx_done;
  logic          any_evt;

  always_comb begin
    uartps_state_t keep;
    logic        acc;
    logic [3:0]  nb;
    logic [15:0] half;
    logic [8:0]  w;
    logic        maj;
    logic        msb;
    logic        par_bad;
    logic        fe_now;
    logic        act;
    logic [19:0] idle_tgt;
    keep = st;
    acc = 1'b0;
    nb = BITS_SHORT;
    half = 16'h0000;
    w = 9'h000;
    maj = 1'b0;
    msb = 1'b0;
    par_bad = 1'b0;
    fe_now = 1'b0;
    act = 1'b0;
    idle_tgt = 20'h0_0000;
    nx = st;
    load_data = 1'b0;
    rx_done = 1'b0;

    nb = st.ctrl1[C1_NINE_BIT] ? BITS_LONG : BITS_SHORT;
    half = {1'b0, st.baud[15:1]};

    // bus address phase; read data registered here with its side effects
    acc = hsel & htrans[1] & hready;
    nx.dp_wr = acc & hwrite;
    nx.dp_addr = haddr[7:0];
    if (acc && !hwrite) begin
      if (haddr[7:0] == OFS_STATUS) begin
        nx.rdata = {24'h00_0000, st.status};
        nx.stat_seen = 1'b1;
      end else if (haddr[7:0] == OFS_DATA) begin
        nx.rdata = {24'h00_0000, st.rx_hold};
        if (st.stat_seen) begin
          nx.stat_seen = 1'b0;
          nx.status[FLG_RX_FULL] = 1'b0;
          nx.status[FLG_IDLE] = 1'b0;
          nx.status[FLG_OVERRUN] = 1'b0;
          nx.status[FLG_NOISE] = 1'b0;
          nx.status[FLG_FRAMING] = 1'b0;
          nx.status[FLG_PARITY] = 1'b0;
        end
      end else if (haddr[7:0] == OFS_CTRL1) begin
        nx.rdata = {24'h00_0000, st.ctrl1};
      end else if (haddr[7:0] == OFS_CTRL2) begin
        nx.rdata = {24'h00_0000, st.ctrl2};
      end else if (haddr[7:0] == OFS_CTRL3) begin
        nx.rdata = {24'h00_0000, st.ctrl3};
      end else if (haddr[7:0] == OFS_BAUD) begin
        nx.rdata = {16'h0000, st.baud};
      end else begin
        nx.rdata = 32'h0000_0000;
      end
    end

    // bus data phase writes
    if (st.dp_wr) begin
      if (st.dp_addr == OFS_DATA) begin
        nx.tx_hold = hwdata[7:0];
        nx.hold_full = 1'b1;
        if (st.stat_seen) begin
          nx.stat_seen = 1'b0;
          nx.status[FLG_TX_EMPTY] = 1'b0;
          nx.status[FLG_TX_DONE] = 1'b0;
          nx.status[FLG_PARITY] = 1'b0;
        end
      end else if (st.dp_addr == OFS_CTRL1) begin
        nx.ctrl1 = {st.ctrl1[C1_RX_BIT8], hwdata[6:0]};
      end else if (st.dp_addr == OFS_CTRL2) begin
        nx.ctrl2 = hwdata[7:0];
        // a rising transmit enable queues an idle preamble
        if (hwdata[C2_TX_EN] && !st.ctrl2[C2_TX_EN]) begin
          nx.pend_idle = 1'b1;
        end
      end else if (st.dp_addr == OFS_CTRL3) begin
        nx.ctrl3 = hwdata[7:0] & CTRL3_WMASK;
      end else if (st.dp_addr == OFS_BAUD) begin
        nx.baud = hwdata[15:0];
      end
    end

    // transmitter; a frame in flight always finishes
    if (st.txst == TX_IDLE) begin
      nx.tx_cnt = 16'h0000;
      nx.tx_bit = 4'h0;
      if (st.ctrl2[C2_TX_EN]) begin
        if (nx.pend_idle) begin
          nx.pend_idle = 1'b0;
          nx.txst = TX_RUN;
          nx.kind = K_IDLE;
        end else if (st.ctrl2[C2_BREAK]) begin
          nx.txst = TX_RUN;
          nx.kind = K_BREAK;
        end else if (st.hold_full) begin
          load_data = 1'b1;
          nx.txst = TX_RUN;
          nx.kind = K_DATA;
          nx.hold_full = 1'b0;
          nx.status[FLG_TX_EMPTY] = 1'b1;
          w = {st.ctrl1[C1_TX_BIT8], st.tx_hold};
          if (st.ctrl1[C1_PAR_EN]) begin
            // even: xor of data bits; odd: its complement
            if (st.ctrl1[C1_NINE_BIT]) begin
              w[8] = (^w[7:0]) ^ st.ctrl1[C1_PAR_ODD];
            end else begin
              w[7] = (^w[6:0]) ^ st.ctrl1[C1_PAR_ODD];
            end
          end
          nx.tx_shift = w;
        end
      end
    end else begin
      if (st.tx_cnt >= st.baud - 16'h0001) begin
        nx.tx_cnt = 16'h0000;
        if (st.tx_bit == nb + 4'h1) begin
          nx.txst = TX_IDLE;
          if (st.kind == K_DATA) begin
            nx.status[FLG_TX_DONE] = 1'b1;
          end
        end else begin
          nx.tx_bit = st.tx_bit + 4'h1;
          if (st.tx_bit != 4'h0) begin
            nx.tx_shift = {1'b0, st.tx_shift[8:1]};
          end
        end
      end else begin
        nx.tx_cnt = st.tx_cnt + 16'h0001;
      end
    end

    // line and sync clock registered from the next state, so they align
    if (nx.txst == TX_IDLE || nx.kind == K_IDLE) begin
      nx.tx_line = 1'b1;
    end else if (nx.kind == K_BREAK || nx.tx_bit == 4'h0) begin
      nx.tx_line = 1'b0;
    end else if (nx.tx_bit > nb) begin
      nx.tx_line = 1'b1;
    end else begin
      nx.tx_line = nx.tx_shift[0];
    end
    act = st.ctrl3[C3_CLK_EN] && nx.txst == TX_RUN && nx.kind == K_DATA
          && nx.tx_bit != 4'h0
          && (nx.tx_bit < nb
              || (nx.tx_bit == nb && st.ctrl3[C3_LAST_PULSE]));
    if (act) begin
      // one active half per bit: first half or second half
      if (st.ctrl3[C3_CLK_PHASE]) begin
        act = nx.tx_cnt < half;
      end else begin
        act = nx.tx_cnt >= half;
      end
    end
    nx.sclk = st.ctrl3[C3_CLK_IDLE] ^ act;

    // receiver; three-sample majority at mid-bit
    nx.rx_hist = {st.rx_hist[1:0], rx_in};
    maj = (st.rx_hist[0] & st.rx_hist[1]) | (st.rx_hist[0] & st.rx_hist[2])
        | (st.rx_hist[1] & st.rx_hist[2]);
    idle_tgt = {4'h0, st.baud}
             * {16'h0000, (st.ctrl1[C1_NINE_BIT] ? FRAME_LONG : FRAME_SHORT)};
    if (st.rxst == RX_IDLE) begin
      if (st.ctrl2[C2_RX_EN] && !rx_in) begin
        nx.rxst = RX_RUN;
        nx.rx_cnt = 16'h0000;
        nx.rx_bit = 4'h0;
        nx.rx_noise = 1'b0;
        nx.idle_cnt = 20'h0_0000;
      end else if (st.ctrl2[C2_RX_EN] && st.idle_cnt < idle_tgt) begin
        nx.idle_cnt = st.idle_cnt + 20'h0_0001;
        if (st.idle_cnt == idle_tgt - 20'h0_0001 && st.idle_armed) begin
          nx.idle_armed = 1'b0;
          if (st.ctrl2[C2_MUTE] && !st.ctrl1[C1_WAKE_ADDR]) begin
            nx.ctrl2[C2_MUTE] = 1'b0;
          end else if (!st.ctrl2[C2_MUTE]) begin
            nx.status[FLG_IDLE] = 1'b1;
          end
        end
      end
    end else begin
      nx.rx_cnt = (st.rx_cnt >= st.baud - 16'h0001) ? 16'h0000
                                                      : st.rx_cnt + 16'h0001;
      if (st.rx_cnt >= st.baud - 16'h0001) begin
        nx.rx_bit = st.rx_bit + 4'h1;
      end
      if (st.rx_cnt == half) begin
        nx.rx_noise = st.rx_noise | ~(&st.rx_hist) & (|st.rx_hist);
        if (st.rx_bit == 4'h0) begin
          if (maj) begin
            nx.rxst = RX_IDLE;
          end
        end else if (st.rx_bit <= nb) begin
          nx.rx_shift = {maj, st.rx_shift[8:1]};
        end else begin
          rx_done = 1'b1;
          fe_now = ~maj;
          nx.rxst = RX_IDLE;
          nx.idle_cnt = 20'h0_0000;
        end
      end
    end
    if (rx_done) begin
      w = st.ctrl1[C1_NINE_BIT] ? st.rx_shift : {1'b0, st.rx_shift[8:1]};
      if (st.ctrl1[C1_PAR_EN]) begin
        msb = st.ctrl1[C1_NINE_BIT] ? w[7] : w[6];
        par_bad = (st.ctrl1[C1_NINE_BIT] ? ^w[8:0] : ^w[7:0])
                  != st.ctrl1[C1_PAR_ODD];
      end else begin
        msb = st.ctrl1[C1_NINE_BIT] ? w[8] : w[7];
      end
      if (st.ctrl2[C2_MUTE] && st.ctrl1[C1_WAKE_ADDR] && msb) begin
        nx.ctrl2[C2_MUTE] = 1'b0;
      end
      if (!nx.ctrl2[C2_MUTE]) begin
        if (nx.status[FLG_RX_FULL]) begin
          // holding word kept, framing error hidden by overrun
          nx.status[FLG_OVERRUN] = 1'b1;
        end else begin
          nx.rx_hold = w[7:0];
          nx.ctrl1[C1_RX_BIT8] = w[8];
          nx.status[FLG_RX_FULL] = 1'b1;
          nx.status[FLG_NOISE] = st.rx_noise | nx.rx_noise;
          nx.status[FLG_FRAMING] = fe_now;
          nx.status[FLG_PARITY] = par_bad;
          nx.idle_armed = 1'b1;
        end
      end
    end

    // halt freezes everything except the bus pipeline
    if (halt_mode) begin
      keep = nx;
      nx = st;
      nx.dp_wr = keep.dp_wr;
      nx.dp_addr = keep.dp_addr;
      nx.rdata = keep.rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.status <= STATUS_RST;
      st.ctrl1 <= CTRL1_RST;
      st.ctrl2 <= CTRL2_RST;
      st.ctrl3 <= CTRL3_RST;
      st.baud <= BAUD_RST;
      st.txst <= TX_IDLE;
      st.rxst <= RX_IDLE;
      st.kind <= K_DATA;
      st.tx_line <= 1'b1;
      st.rx_hist <= 3'h7;
    end else begin
      st <= nx;
    end
  end

  assign any_evt = (st.status[FLG_TX_EMPTY] & st.ctrl2[C2_TX_EMPTY_IE])
                 | (st.status[FLG_TX_DONE] & st.ctrl2[C2_TX_DONE_IE])
                 | ((st.status[FLG_RX_FULL] | st.status[FLG_OVERRUN])
                    & st.ctrl2[C2_RX_IE])
                 | (st.status[FLG_IDLE] & st.ctrl2[C2_IDLE_IE])
                 | (st.status[FLG_PARITY] & st.ctrl1[C1_PAR_IE]);
  assign irq = any_evt & ~cpu_int_mask & ~halt_mode;
  assign wake_req = irq & wait_mode;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign tx_oe = st.ctrl2[C2_TX_EN] | st.ctrl2[C2_RX_EN];
  assign sclk_oe = tx_oe & st.ctrl3[C3_CLK_EN];
  assign tx_out = st.tx_line;
  assign sclk_out = st.sclk;

  a_irq_mask_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (cpu_int_mask || halt_mode) |-> !irq) else $error("irq while masked");
  a_rx_irq_cover: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st.status[FLG_OVERRUN] && st.ctrl2[C2_RX_IE] && !cpu_int_mask
     && !halt_mode) |-> irq) else $error("overrun irq missing");
  a_pins_float: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(st.ctrl2[C2_TX_EN] || st.ctrl2[C2_RX_EN]) |-> !tx_oe && !sclk_oe)
    else $error("pins driven while disabled");
  // sclk is registered from the state it stands with, so judge that state
  a_sclk_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st.txst == TX_RUN
    && (st.kind != K_DATA || st.tx_bit == 4'h0
        || st.tx_bit > (st.ctrl1[C1_NINE_BIT] ? BITS_LONG : BITS_SHORT)
        || (st.tx_bit == (st.ctrl1[C1_NINE_BIT] ? BITS_LONG : BITS_SHORT)
            && !st.ctrl3[C3_LAST_PULSE]))
    |-> sclk_out == st.ctrl3[C3_CLK_IDLE])
    else $error("sync clock active outside data bits");
  a_halt_freeze: assert property (
    @(posedge hclk) disable iff (!hresetn)
    halt_mode |=> st.status == $past(st.status)
                  && st.tx_cnt == $past(st.tx_cnt))
    else $error("state moved during halt");
  a_empty_on_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    load_data && !halt_mode |=> st.status[FLG_TX_EMPTY] && !st.hold_full)
    else $error("empty flag not set on load");
  a_done_data_only: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(st.status[FLG_TX_DONE]) |-> $past(st.kind) == K_DATA)
    else $error("complete flag after non-data frame");
  a_tx_parity: assert property (
    @(posedge hclk) disable iff (!hresetn)
    load_data && !halt_mode && st.ctrl1[C1_PAR_EN] && !st.ctrl1[C1_NINE_BIT]
    |=> (^st.tx_shift[7:0]) == st.ctrl1[C1_PAR_ODD])
    else $error("transmit parity wrong");
  // a data read in the same cycle may free the holding register
  a_overrun_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_done && !halt_mode && st.status[FLG_RX_FULL] && !st.ctrl2[C2_MUTE]
    && !(hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_DATA)
    |=> st.status[FLG_OVERRUN] && st.rx_hold == $past(st.rx_hold))
    else $error("overrun lost holding word");
  a_wake_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wake_req |-> wait_mode && !halt_mode && irq)
    else $error("wake outside wait");

endmodule : uartps_core

`default_nettype wire

// ==== hdl/uartps_pkg.sv ====
// constants, field positions and state record of the serial parity/status block
`default_nettype none

package uartps_pkg;

  // byte offsets on the bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_CTRL1  = 8'h08;
  localparam logic [7:0] OFS_CTRL2  = 8'h0C;
  localparam logic [7:0] OFS_CTRL3  = 8'h10;
  localparam logic [7:0] OFS_BAUD   = 8'h14;

  // reset values and the control_three write mask
  localparam logic [7:0]  STATUS_RST = 8'hC0;
  localparam logic [7:0]  CTRL1_RST  = 8'h00;
  localparam logic [7:0]  CTRL2_RST  = 8'h00;
  localparam logic [7:0]  CTRL3_RST  = 8'h00;
  localparam logic [15:0] BAUD_RST   = 16'h0010;
  localparam logic [7:0]  CTRL3_WMASK = 8'h4F;

  // status bits
  localparam int FLG_TX_EMPTY = 7;
  localparam int FLG_TX_DONE  = 6;
  localparam int FLG_RX_FULL  = 5;
  localparam int FLG_IDLE     = 4;
  localparam int FLG_OVERRUN  = 3;
  localparam int FLG_NOISE    = 2;
  localparam int FLG_FRAMING  = 1;
  localparam int FLG_PARITY   = 0;

  // control_one bits
  localparam int C1_RX_BIT8   = 7;
  localparam int C1_TX_BIT8   = 6;
  localparam int C1_NINE_BIT  = 4;
  localparam int C1_WAKE_ADDR = 3;
  localparam int C1_PAR_EN    = 2;
  localparam int C1_PAR_ODD   = 1;
  localparam int C1_PAR_IE    = 0;

  // control_two bits
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE  = 6;
  localparam int C2_RX_IE       = 5;
  localparam int C2_IDLE_IE     = 4;
  localparam int C2_TX_EN       = 3;
  localparam int C2_RX_EN       = 2;
  localparam int C2_MUTE        = 1;
  localparam int C2_BREAK       = 0;

  // control_three bits
  localparam int C3_CLK_EN    = 3;
  localparam int C3_CLK_IDLE  = 2;
  localparam int C3_CLK_PHASE = 1;
  localparam int C3_LAST_PULSE = 0;

  // frame bit counts
  localparam logic [3:0] BITS_SHORT  = 4'h8;
  localparam logic [3:0] BITS_LONG   = 4'h9;
  localparam logic [3:0] FRAME_SHORT = 4'hA;
  localparam logic [3:0] FRAME_LONG  = 4'hB;

  typedef enum logic {TX_IDLE, TX_RUN} uartps_txst_t;
  typedef enum logic {RX_IDLE, RX_RUN} uartps_rxst_t;
  typedef enum logic [1:0] {K_DATA, K_IDLE, K_BREAK} uartps_kind_t;

  typedef struct packed {
    logic [7:0]   status;
    logic [7:0]   ctrl1;
    logic [7:0]   ctrl2;
    logic [7:0]   ctrl3;
    logic [15:0]  baud;
    logic [7:0]   tx_hold;
    logic         hold_full;
    logic         stat_seen;
    logic         pend_idle;
    logic         dp_wr;
    logic [7:0]   dp_addr;
    logic [31:0]  rdata;
    uartps_txst_t txst;
    uartps_kind_t kind;
    logic [3:0]   tx_bit;
    logic [15:0]  tx_cnt;
    logic [8:0]   tx_shift;
    logic         tx_line;
    logic         sclk;
    uartps_rxst_t rxst;
    logic [3:0]   rx_bit;
    logic [15:0]  rx_cnt;
    logic [8:0]   rx_shift;
    logic [2:0]   rx_hist;
    logic         rx_noise;
    logic [19:0]  idle_cnt;
    logic         idle_armed;
    logic [7:0]   rx_hold;
  } uartps_state_t;

endpackage : uartps_pkg

`default_nettype wire

// ==== bench/uartps_peer.sv ====
// far-end serial peer: frame sender, frame receiver, clock edge counter
`default_nettype none

module uartps_peer #(
  parameter int BAUD = 8
) (
  // clock
  input  wire logic       hclk,
  // lines at the pins
  input  wire logic       line_in,
  input  wire logic       sclk_in,
  output logic            line_out,
  // captured frames and clock edge count
  output logic [7:0]      got,
  output int              n_got,
  output int              toggles
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sclk_q;

  initial begin
    line_out = 1'h1;
    got = 8'h00;
    n_got = 0;
    toggles = 0;
    sclk_q = 1'h0;
  end

  // sampled on the falling edge, clear of the block's launch edge
  always begin
    @(negedge hclk);
    if (line_in === 1'h0) begin
      repeat (BAUD / 2 + BAUD) @(negedge hclk);
      for (int i = 0; i < 8; i++) begin
        got[i] = line_in;
        repeat (BAUD) @(negedge hclk);
      end
      n_got = n_got + 1;
    end
  end

  // counts every edge; the bench takes differences
  always @(negedge hclk) begin
    if (sclk_in !== sclk_q) begin
      toggles <= toggles + 1;
    end
    sclk_q <= sclk_in;
  end

  // start, n bits lsb first, one stop bit
  task automatic send(input logic [8:0] bits, input int n);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge hclk);
      line_out <= (i == 0) ? 1'h0 : (i > n) ? 1'h1 : bits[i - 1];
      repeat (BAUD - 1) @(posedge hclk);
    end
  endtask : send
endmodule : uartps_peer

`default_nettype wire

// ==== bench/tb.sv ====
// testbench of the serial parity, status and sync clock block
`default_nettype none

module tb
  import uartps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 8;

  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        cpu_int_mask = 1'h0;
  logic        wait_mode = 1'h0;
  logic        halt_mode = 1'h0;
  logic        hreadyout, hresp, irq, wake_req;
  logic [31:0] hrdata, q;
  logic        rx_in, tx_out, tx_oe, sclk_out, sclk_oe, line;
  logic [7:0]  got;
  int          n_got, toggles;
  int          n_errors = 0;
  int          n_compared = 0;

  always #4 hclk = ~hclk;
  // a released transmit pin is pulled high
  assign line = tx_oe ? tx_out : 1'h1;

  uartps_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_int_mask(cpu_int_mask), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .irq(irq), .wake_req(wake_req), .rx_in(rx_in),
    .tx_out(tx_out), .tx_oe(tx_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe)
  );

  uartps_peer #(.BAUD(BT)) peer (
    .hclk(hclk), .line_in(line), .sclk_in(sclk_out), .line_out(rx_in),
    .got(got), .n_got(n_got), .toggles(toggles)
  );

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic hang(input string what);
    n_errors++;
    $display("CHECK FAILED t=%0t %s", $time, what);
    report_and_stop();
  endtask : hang

  task automatic cmp1(input logic g, input logic e, input string what);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %b", $time, what, g);
    end
  endtask : cmp1

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e,
                      input string what);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : cmp8

  task automatic cmpn(input int g, input int e, input string what);
    n_compared++;
    if (g != e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, g, e);
    end
  endtask : cmpn

  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'h1 && i < 64);
    if (hreadyout !== 1'h1) hang("bus hang");
  endtask : wait_rdy

  // one single word transfer; read data lands in q
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'h1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(a, 1'h0, 8'h00);
  endtask : rd

  task automatic t_reset();
    logic [7:0] ofs [6] = '{OFS_STATUS, OFS_CTRL1, OFS_CTRL2, OFS_CTRL3,
                            OFS_BAUD, 8'h3C};
    logic [7:0] exp [6] = '{8'hC0, 8'h00, 8'h00, 8'h00, BAUD_RST[7:0], 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      cmp8(q[7:0], exp[i], "reset value");
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx(input logic odd, input logic [7:0] c3,
                      input logic [7:0] exp, input int pulses);
    int n0;
    int t0;
    wr(OFS_CTRL2, 8'h00);
    @(negedge hclk);
    cmp1(tx_oe, 1'h0, "tx pin driven");
    cmp1(sclk_oe, 1'h0, "clock pin driven");
    wr(OFS_BAUD, BT[7:0]);
    wr(OFS_CTRL3, c3);
    wr(OFS_CTRL1, {5'h00, 1'h1, odd, 1'h0});
    wr(OFS_CTRL2, 8'h08);
    @(negedge hclk);
    cmp1(sclk_oe, 1'h1, "clock pin idle");
    cmp1(sclk_out, c3[2], "clock rest level");
    rd(OFS_STATUS);
    n0 = n_got;
    t0 = toggles;
    wr(OFS_DATA, 8'h35);
    for (int i = 0; i < 3000 && n_got == n0; i++) @(negedge hclk);
    if (n_got == n0) hang("no frame");
    rd(OFS_STATUS);
    cmp1(q[FLG_TX_DONE], 1'h0, "done after idle frame");
    cmp8(got, exp, "sent byte");
    repeat (2 * BT) @(negedge hclk);
    rd(OFS_STATUS);
    cmp1(q[FLG_TX_DONE], 1'h1, "tx done");
    cmp1(q[FLG_TX_EMPTY], 1'h1, "tx empty");
    cmpn(toggles - t0, 2 * pulses, "clock edges");
    cmp1(sclk_out, c3[2], "clock rest after");
    $display("test tx done");
  endtask : t_tx

  task automatic t_rx();
    wr(OFS_CTRL2, 8'h04);
    wr(OFS_CTRL1, 8'h05);
    peer.send(9'h0B5, 8);
    rd(OFS_STATUS);
    cmp1(q[FLG_PARITY], 1'h1, "parity error");
    cmp1(q[FLG_RX_FULL], 1'h1, "rx full");
    cmp1(q[FLG_NOISE], 1'h0, "noise");
    cmp1(irq, 1'h1, "parity irq");
    @(posedge hclk);
    cpu_int_mask <= 1'h1;
    @(negedge hclk);
    cmp1(irq, 1'h0, "masked irq");
    @(posedge hclk);
    cpu_int_mask <= 1'h0;
    wait_mode <= 1'h1;
    @(negedge hclk);
    cmp1(wake_req, 1'h1, "wake");
    @(posedge hclk);
    wait_mode <= 1'h0;
    rd(OFS_DATA);
    cmp8(q[7:0] & 8'h7F, 8'h35, "rx data");
    rd(OFS_STATUS);
    cmp8(q[7:0] & 8'h21, 8'h00, "flags cleared");
    peer.send(9'h035, 8);
    rd(OFS_STATUS);
    cmp8(q[7:0] & 8'h21, 8'h20, "good parity");
    rd(OFS_DATA);
    $display("test rx parity done");
  endtask : t_rx

  task automatic t_ovr();
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL2, 8'h24);
    peer.send(9'h05A, 8);
    @(negedge hclk);
    cmp1(irq, 1'h1, "rx irq");
    peer.send(9'h0A3, 8);
    rd(OFS_STATUS);
    cmp8(q[7:0] & 8'h2A, 8'h28, "overrun");
    rd(OFS_DATA);
    cmp8(q[7:0], 8'h5A, "held word");
    // low ninth bit falls on the stop slot
    peer.send(9'h055, 9);
    rd(OFS_STATUS);
    cmp8(q[7:0] & 8'h2A, 8'h22, "framing");
    rd(OFS_DATA);
    repeat (12 * BT) @(negedge hclk);
    rd(OFS_STATUS);
    cmp1(q[FLG_IDLE], 1'h1, "idle line");
    rd(OFS_DATA);
    repeat (12 * BT) @(negedge hclk);
    rd(OFS_STATUS);
    cmp1(q[FLG_IDLE], 1'h0, "idle once");
    $display("test overrun done");
  endtask : t_ovr

  task automatic t_wake();
    wr(OFS_CTRL1, 8'h0C);
    wr(OFS_CTRL2, 8'h06);
    // parity bit high but data msb low: must stay muted
    peer.send(9'h081, 8);
    rd(OFS_STATUS);
    cmp1(q[FLG_RX_FULL], 1'h0, "muted word");
    rd(OFS_CTRL2);
    cmp8(q[7:0], 8'h06, "still muted");
    peer.send(9'h041, 8);
    rd(OFS_STATUS);
    cmp1(q[FLG_RX_FULL], 1'h1, "address wake");
    rd(OFS_CTRL2);
    cmp8(q[7:0], 8'h04, "mute cleared");
    rd(OFS_DATA);
    cmp8(q[7:0], 8'h41, "address word");
    wr(OFS_CTRL1, 8'h00);
    $display("test wake done");
  endtask : t_wake

  task automatic t_halt();
    @(posedge hclk);
    halt_mode <= 1'h1;
    wr(OFS_CTRL1, 8'h07);
    peer.send(9'h012, 8);
    rd(OFS_CTRL1);
    cmp8(q[7:0], 8'h00, "frozen reg");
    rd(OFS_STATUS);
    cmp1(q[FLG_RX_FULL], 1'h0, "rx in halt");
    @(posedge hclk);
    halt_mode <= 1'h0;
    wr(OFS_CTRL1, 8'h07);
    rd(OFS_CTRL1);
    cmp8(q[7:0], 8'h07, "reg after halt");
    $display("test halt done");
  endtask : t_halt

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_tx(1'h0, 8'h08, 8'h35, 7);
    t_tx(1'h1, 8'h0F, 8'hB5, 8);
    t_rx();
    t_ovr();
    t_wake();
    t_halt();
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
